// ---- pao_pkg.sv ----
// Purpose: constants shared by the phase accumulator oscillator
// Assumes: 8-bit register port, single clock domain
// Notes: register offsets are local indices of this block
package pao_pkg;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFF_CONTROL = 4'h0;
  localparam logic [3:0] OFF_CLOCK = 4'h1;
  localparam logic [3:0] OFF_ACC_LOW = 4'h2;
  localparam logic [3:0] OFF_ACC_HIGH = 4'h3;
  localparam logic [3:0] OFF_ACC_UPPER = 4'h4;
  localparam logic [3:0] OFF_STEP_LOW = 4'h5;
  localparam logic [3:0] OFF_STEP_HIGH = 4'h6;
  localparam logic [3:0] OFF_STEP_UPPER = 4'h7;
  localparam int unsigned ACC_W = 20;
  localparam int unsigned BIT_ENABLE = 7;
  localparam int unsigned BIT_LEVEL = 5;
  localparam int unsigned BIT_INVERT = 4;
  localparam int unsigned BIT_PFM = 0;
  localparam int unsigned PWS_LSB = 5;
  localparam logic [7:0] CONTROL_WMASK = 8'h91;
  localparam logic [7:0] CLOCK_WMASK = 8'hef;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [3:0] CKS_SYSTEM = 4'h0;
  localparam logic [3:0] CKS_HFINT = 4'h1;
  localparam logic [3:0] CKS_LFINT = 4'h2;
  localparam logic [3:0] CKS_MF500K = 4'h3;
  localparam logic [3:0] CKS_MF32K = 4'h4;
  localparam logic [3:0] CKS_REFCLK = 4'h6;
  localparam logic [3:0] CKS_LC1 = 4'h7;
  localparam logic [3:0] CKS_LC2 = 4'h8;
  localparam logic [3:0] CKS_LC3 = 4'h9;
  localparam logic [3:0] CKS_LC4 = 4'ha;
endpackage : pao_pkg

// ---- pao_edge_det.sv ----
// Purpose: rising edge detector for the selected clock source level
// Assumes: input already synchronous to clk_sys
// Notes: one-cycle pulse per rising edge
module pao_edge_det (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // level in, pulse out
  input wire logic level_in,
  output logic rise_pulse
);
  logic prev_ff;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= level_in;
    end
  end
  assign rise_pulse = level_in & ~prev_ff;
endmodule : pao_edge_det

// ---- pao_osc.sv ----
// Purpose: phase accumulator oscillator control, accumulator and output shaping
// Assumes: source clocks are levels synchronous to clk_sys; each rising edge is one input clock
// Notes: the accumulator advances on detected source edges, not on clk_sys
// Notes on behaviour
// - oscillator advances only while the enable bit is one.
// - output level bit reads the present module output.
// - invert bit set drives the module output inverted.
// - mode bit set gives a pulse of selectable width per overflow.
// - mode bit clear toggles output on each overflow, halving the rate.
// - pulse lasts two to the power of the width code input periods.
// - pulse width code matters only in pulse mode.
// - clock codes six to ten pick reference clock and logic cells; above reserved.
// - codes one to four pick internal oscillators; five is reserved.
// - accumulator read as three bytes; upper nibble of top byte reads zero.
// - accumulator updates continuously; multi-byte reads are not coherent.
// - unimplemented control and clock bits read as zero.
// - each input edge adds the step value; carry is the overflow event.
// - pulse output goes active on the first input edge after overflow.
// - reset clears every register to zero.
// - pulse longer than overflow interval keeps the output from toggling.
module pao_osc (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // clock sources
  input wire logic system_osc_clk,
  input wire logic high_freq_internal_osc,
  input wire logic low_freq_internal_osc,
  input wire logic medium_freq_internal_osc_500k,
  input wire logic medium_freq_internal_osc_32k,
  input wire logic reference_clock_out,
  input wire logic logic_cell_one_out,
  input wire logic logic_cell_two_out,
  input wire logic logic_cell_three_out,
  input wire logic logic_cell_four_out,
  // outputs to peripherals
  output logic osc_out,
  output logic acc_carry_event
);
  logic [7:0] control_ff;
  logic [7:0] clock_cfg_ff;
  logic [19:0] acc_ff;
  logic [19:0] step_ff;
  logic [7:0] rdata_ff;
  logic level_ff;
  logic carry_ff;
  logic pend_ff;
  logic [7:0] width_cnt_ff;
  logic [19:0] nxt_acc;
  logic nxt_level;
  logic [7:0] nxt_width_cnt;
  logic nxt_pend;

  wire osc_enable = control_ff[pao_pkg::BIT_ENABLE];
  wire output_invert = control_ff[pao_pkg::BIT_INVERT];
  wire pulse_freq_select = control_ff[pao_pkg::BIT_PFM];
  wire [2:0] pulse_width_select = clock_cfg_ff[pao_pkg::PWS_LSB +: 3];
  wire [3:0] clock_source_select = clock_cfg_ff[3:0];

  // source multiplexer; reserved codes give a stopped clock
  logic src_level;
  always_comb begin
    case (clock_source_select)
      pao_pkg::CKS_SYSTEM: src_level = system_osc_clk;
      pao_pkg::CKS_HFINT: src_level = high_freq_internal_osc;
      pao_pkg::CKS_LFINT: src_level = low_freq_internal_osc;
      pao_pkg::CKS_MF500K: src_level = medium_freq_internal_osc_500k;
      pao_pkg::CKS_MF32K: src_level = medium_freq_internal_osc_32k;
      pao_pkg::CKS_REFCLK: src_level = reference_clock_out;
      pao_pkg::CKS_LC1: src_level = logic_cell_one_out;
      pao_pkg::CKS_LC2: src_level = logic_cell_two_out;
      pao_pkg::CKS_LC3: src_level = logic_cell_three_out;
      pao_pkg::CKS_LC4: src_level = logic_cell_four_out;
      default: src_level = 1'b0;
    endcase
  end

  logic src_edge;
  pao_edge_det u_edge (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .level_in(src_level),
    .rise_pulse(src_edge)
  );

  wire tick = src_edge & osc_enable;
  wire [20:0] sum = {1'b0, acc_ff} + {1'b0, step_ff};
  wire overflow = tick & sum[20];

  // decoded register accesses
  wire wr_control = reg_wr & (reg_addr == pao_pkg::OFF_CONTROL);
  wire wr_clock = reg_wr & (reg_addr == pao_pkg::OFF_CLOCK);
  wire wr_acc_l = reg_wr & (reg_addr == pao_pkg::OFF_ACC_LOW);
  wire wr_acc_h = reg_wr & (reg_addr == pao_pkg::OFF_ACC_HIGH);
  wire wr_acc_u = reg_wr & (reg_addr == pao_pkg::OFF_ACC_UPPER);
  wire wr_step_l = reg_wr & (reg_addr == pao_pkg::OFF_STEP_LOW);
  wire wr_step_h = reg_wr & (reg_addr == pao_pkg::OFF_STEP_HIGH);
  wire wr_step_u = reg_wr & (reg_addr == pao_pkg::OFF_STEP_UPPER);

  // pulse length 2^n periods, counted in input edges
  wire [7:0] width_periods = 8'h01 << pulse_width_select;

  // accumulator: a software write wins over an edge; writing while running is undefined anyway
  always_comb begin
    nxt_acc = acc_ff;
    if (tick) begin
      nxt_acc = sum[19:0];
    end
    if (wr_acc_l) begin
      nxt_acc = {acc_ff[19:8], reg_wdata};
    end
    if (wr_acc_h) begin
      nxt_acc = {acc_ff[19:16], reg_wdata, acc_ff[7:0]};
    end
    if (wr_acc_u) begin
      nxt_acc = {reg_wdata[3:0], acc_ff[15:0]};
    end
  end

  // output shaping
  always_comb begin
    nxt_level = level_ff;
    nxt_width_cnt = width_cnt_ff;
    nxt_pend = pend_ff;
    if (!osc_enable) begin
      nxt_pend = 1'b0;
    end else if (!pulse_freq_select) begin
      nxt_pend = 1'b0;
      nxt_width_cnt = 8'h00;
      if (overflow) begin
        nxt_level = ~level_ff;
      end
    end else begin
      // overflow arms; the following input edge raises the output
      if (tick && pend_ff) begin
        nxt_level = 1'b1;
        nxt_width_cnt = width_periods;
        nxt_pend = overflow;
      end else if (tick && level_ff) begin
        if (width_cnt_ff <= 8'h01) begin
          nxt_level = 1'b0;
          nxt_width_cnt = 8'h00;
        end else begin
          nxt_width_cnt = width_cnt_ff - 8'h01;
        end
        // a new overflow during the pulse arms a restart at the next edge; an overflow on its last edge drops it for one period
        if (overflow) begin
          nxt_pend = 1'b1;
        end
      end else if (overflow) begin
        nxt_pend = 1'b1;
      end
    end
  end

  // readback
  wire [7:0] control_rd = (control_ff & pao_pkg::CONTROL_WMASK) | ({7'h00, osc_out} << pao_pkg::BIT_LEVEL);
  wire [7:0] clock_rd = clock_cfg_ff & pao_pkg::CLOCK_WMASK;
  logic [7:0] rd_mux;
  always_comb begin
    case (reg_addr)
      pao_pkg::OFF_CONTROL: rd_mux = control_rd;
      pao_pkg::OFF_CLOCK: rd_mux = clock_rd;
      pao_pkg::OFF_ACC_LOW: rd_mux = acc_ff[7:0];
      pao_pkg::OFF_ACC_HIGH: rd_mux = acc_ff[15:8];
      pao_pkg::OFF_ACC_UPPER: rd_mux = {4'h0, acc_ff[19:16]};
      pao_pkg::OFF_STEP_LOW: rd_mux = step_ff[7:0];
      pao_pkg::OFF_STEP_HIGH: rd_mux = step_ff[15:8];
      pao_pkg::OFF_STEP_UPPER: rd_mux = {4'h0, step_ff[19:16]};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      control_ff <= pao_pkg::RESET_BYTE;
      clock_cfg_ff <= pao_pkg::RESET_BYTE;
    end else begin
      if (wr_control) begin
        control_ff <= reg_wdata & pao_pkg::CONTROL_WMASK;
      end
      if (wr_clock) begin
        clock_cfg_ff <= reg_wdata & pao_pkg::CLOCK_WMASK;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      step_ff <= 20'h00000;
    end else begin
      if (wr_step_l) begin
        step_ff[7:0] <= reg_wdata;
      end
      if (wr_step_h) begin
        step_ff[15:8] <= reg_wdata;
      end
      if (wr_step_u) begin
        step_ff[19:16] <= reg_wdata[3:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      acc_ff <= 20'h00000;
      level_ff <= 1'b0;
      pend_ff <= 1'b0;
      width_cnt_ff <= 8'h00;
      carry_ff <= 1'b0;
    end else begin
      acc_ff <= nxt_acc;
      level_ff <= nxt_level;
      pend_ff <= nxt_pend;
      width_cnt_ff <= nxt_width_cnt;
      carry_ff <= overflow;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= rd_mux;
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign osc_out = level_ff ^ output_invert;
  assign acc_carry_event = carry_ff;
  assign reg_rdata = rdata_ff;

  // checks
  // internal state is watched where the pins alone cannot tell why the output moved;
  // each check follows the rule, not the next-state code above
  acc_hold_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!osc_enable && !reg_wr) |=> (acc_ff == $past(acc_ff)))
    else $error("accumulator moved while disabled");
  acc_step_add_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tick && !reg_wr) |=> (acc_ff == 20'($past(acc_ff) + $past(step_ff))))
    else $error("accumulator did not add step");
  level_read_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (reg_rd && reg_addr == pao_pkg::OFF_CONTROL) |=> (reg_rdata[5] == $past(osc_out)))
    else $error("output level bit wrong");
  invert_out_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!osc_enable && wr_control && (reg_wdata[pao_pkg::BIT_INVERT] != output_invert))
      |=> (osc_out != $past(osc_out)))
    else $error("output polarity wrong");
  fdc_toggle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (overflow && !pulse_freq_select) |=> (level_ff != $past(level_ff)))
    else $error("fixed duty did not toggle");
  pulse_rise_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tick && pend_ff && pulse_freq_select) |=> level_ff && width_cnt_ff == $past(width_periods))
    else $error("pulse did not start");
  upper_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (reg_rd && reg_addr == pao_pkg::OFF_ACC_UPPER) |=> (reg_rdata[7:4] == 4'h0))
    else $error("upper nibble not zero");
  unimpl_zero_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (reg_rd && reg_addr == pao_pkg::OFF_CONTROL) |=> (reg_rdata[6] == 1'b0 && reg_rdata[3:1] == 3'h0))
    else $error("unimplemented bits not zero");
  pulse_off_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tick && level_ff && pulse_freq_select && !pend_ff && width_cnt_ff == 8'h01) |=> !level_ff)
    else $error("pulse did not end");

  // carry: a wrap of the accumulator is the only overflow, and it is one cycle wide
  carry_wrap_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tick && !reg_wr) |=> (acc_carry_event == (acc_ff < $past(acc_ff))))
    else $error("carry does not match accumulator wrap");
  carry_idle_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !osc_enable |=> !acc_carry_event)
    else $error("carry while disabled");
  carry_single_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    acc_carry_event |=> !acc_carry_event)
    else $error("carry pulse longer than one cycle");

  // output shaping; the level may only move at input edges
  off_level_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    !osc_enable |=> (level_ff == $past(level_ff)))
    else $error("output moved while disabled");
  fdc_steady_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (osc_enable && !pulse_freq_select && !overflow)
      |=> (level_ff == $past(level_ff)))
    else $error("fixed duty output moved without overflow");
  pfm_arm_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (overflow && pulse_freq_select) |=> pend_ff)
    else $error("overflow did not arm a pulse");
  pfm_wait_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pulse_freq_select && !level_ff && !(tick && pend_ff))
      |=> !level_ff)
    else $error("pulse started without an armed edge");
  pulse_gap_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (pulse_freq_select && level_ff && !tick) |=> level_ff)
    else $error("pulse ended between input edges");
  pulse_hold_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (tick && level_ff && pulse_freq_select && !pend_ff && (width_cnt_ff > 8'h01))
      |=> level_ff)
    else $error("pulse ended early");
  // an overflow inside a long pulse restarts it instead of dropping the output
  long_pulse_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (overflow && level_ff && pulse_freq_select && (width_cnt_ff > 8'h01))
      |=> level_ff)
    else $error("output toggled during an overlong pulse");

  // register port; read data answer one cycle after the strobe
  clock_unimpl_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (reg_rd && reg_addr == pao_pkg::OFF_CLOCK) |=> (reg_rdata[4] == 1'b0))
    else $error("clock register bit four not zero");
  acc_low_rd_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (reg_rd && reg_addr == pao_pkg::OFF_ACC_LOW)
      |=> (reg_rdata == $past(acc_ff[7:0])))
    else $error("accumulator low byte read wrong");
  acc_high_rd_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (reg_rd && reg_addr == pao_pkg::OFF_ACC_HIGH)
      |=> (reg_rdata == $past(acc_ff[15:8])))
    else $error("accumulator high byte read wrong");
  acc_upper_rd_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (reg_rd && reg_addr == pao_pkg::OFF_ACC_UPPER)
      |=> (reg_rdata[3:0] == $past(acc_ff[19:16])))
    else $error("accumulator upper nibble read wrong");
  acc_low_wr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_acc_l |=> (acc_ff[7:0] == $past(reg_wdata)))
    else $error("accumulator low byte write lost");
  acc_upper_wr_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    wr_acc_u |=> (acc_ff[19:16] == $past(reg_wdata[3:0])))
    else $error("accumulator upper nibble write lost");

  // reserved source codes must give a stopped clock, not a stale level
  src_reserved_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (clock_source_select > pao_pkg::CKS_LC4) |-> !tick)
    else $error("reserved source code advanced the accumulator");
  code_five_a: assert property (@(posedge clk_sys) disable iff (!rstn)
    (clock_source_select == 4'h5) |-> !tick)
    else $error("source code five advanced the accumulator");

  cov_fdc_c: cover property (@(posedge clk_sys) disable iff (!rstn) overflow && !pulse_freq_select);
  cov_pfm_c: cover property (@(posedge clk_sys) disable iff (!rstn) tick && pend_ff && pulse_freq_select);
  cov_rd_c: cover property (@(posedge clk_sys) disable iff (!rstn) reg_rd && reg_addr == pao_pkg::OFF_ACC_UPPER);
  cov_long_c: cover property (@(posedge clk_sys) disable iff (!rstn) overflow && level_ff && pulse_freq_select);
  cov_inv_c: cover property (@(posedge clk_sys) disable iff (!rstn)
    wr_control && (reg_wdata[pao_pkg::BIT_INVERT] != output_invert));
endmodule : pao_osc

// ---- pao_peer_model.sv ----
// Purpose: source clock levels and a consumer of the oscillator output
// Assumes: one clock domain, levels change just after clk_sys edges
// Notes: a stopped source rests low, so a burst of 2k toggles gives exactly k rising edges
module pao_peer_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // source control
  input wire logic run,
  input wire logic [9:0] mask,
  output logic [9:0] src_lvl,
  // consumed outputs
  input wire logic osc_out,
  input wire logic acc_carry_event,
  output logic [15:0] hi_cnt_ff,
  output logic [15:0] rise_cnt_ff,
  output logic [15:0] carry_cnt_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lvl_ff;
  logic out_ff;
  assign src_lvl = mask & {10{lvl_ff}};
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      lvl_ff <= 1'b0;
      out_ff <= 1'b0;
      hi_cnt_ff <= 16'h0000;
      rise_cnt_ff <= 16'h0000;
      carry_cnt_ff <= 16'h0000;
    end else begin
      lvl_ff <= run ? ~lvl_ff : lvl_ff;
      out_ff <= osc_out;
      hi_cnt_ff <= hi_cnt_ff + 16'(osc_out);
      rise_cnt_ff <= rise_cnt_ff + 16'(osc_out & ~out_ff);
      carry_cnt_ff <= carry_cnt_ff + 16'(acc_carry_event);
    end
  end
endmodule : pao_peer_model

// ---- phase_accumulator_oscillator_tb.sv ----
// Purpose: register-level tests of the phase accumulator oscillator
// Assumes: read data sampled in the cycle after the strobe
// Notes: accumulator is only written while disabled, since live writes are undefined
module phase_accumulator_oscillator_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic run = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [9:0] mask = 10'h000;
  logic [9:0] src_lvl;
  logic osc_out;
  logic acc_carry_event;
  logic [15:0] hi_cnt_ff, rise_cnt_ff, carry_cnt_ff, b_hi, b_rise, b_carry;
  int fails = 0;
  int compares = 0;
  // source index per clock code, f marks no source
  logic [3:0] src_idx [16] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hf, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9,
    4'hf, 4'hf, 4'hf, 4'hf, 4'hf};
  pao_osc u_pao_osc (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .system_osc_clk(src_lvl[0]),
    .high_freq_internal_osc(src_lvl[1]), .low_freq_internal_osc(src_lvl[2]),
    .medium_freq_internal_osc_500k(src_lvl[3]), .medium_freq_internal_osc_32k(src_lvl[4]),
    .reference_clock_out(src_lvl[5]), .logic_cell_one_out(src_lvl[6]), .logic_cell_two_out(src_lvl[7]),
    .logic_cell_three_out(src_lvl[8]), .logic_cell_four_out(src_lvl[9]), .osc_out(osc_out),
    .acc_carry_event(acc_carry_event));
  pao_peer_model u_pao_peer_model (.clk_sys(clk_sys), .rstn(rstn), .run(run), .mask(mask),
    .src_lvl(src_lvl), .osc_out(osc_out), .acc_carry_event(acc_carry_event), .hi_cnt_ff(hi_cnt_ff),
    .rise_cnt_ff(rise_cnt_ff), .carry_cnt_ff(carry_cnt_ff));
  initial begin
    forever #20 clk_sys = ~clk_sys;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata});
  endtask : rd_chk
  task automatic set3(input logic [3:0] a, input logic [19:0] v);
    wr(a, v[7:0]);
    wr(a + 4'h1, v[15:8]);
    wr(a + 4'h2, {4'h0, v[19:16]});
  endtask : set3
  task automatic tick(input int k, input logic [9:0] m);
    @(posedge clk_sys);
    run <= 1'b1;
    mask <= m;
    repeat (2 * k) @(posedge clk_sys);
    run <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask : tick
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    #200000;
    fails++;
    close_out();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 9; i++) rd_chk(4'(i), 8'h00);
    wr(pao_pkg::OFF_CONTROL, 8'hff);
    rd_chk(pao_pkg::OFF_CONTROL, 8'hb1);
    wr(pao_pkg::OFF_CLOCK, 8'hff);
    rd_chk(pao_pkg::OFF_CLOCK, 8'hef);
    wr(4'h9, 8'h5a);
    rd_chk(4'h9, 8'h00);
    wr(pao_pkg::OFF_CONTROL, 8'h00);
    wr(pao_pkg::OFF_CLOCK, 8'h00);
    set3(pao_pkg::OFF_ACC_LOW, 20'hfff00);
    rd_chk(pao_pkg::OFF_ACC_UPPER, 8'h0f);
    wr(pao_pkg::OFF_ACC_UPPER, 8'hf5);
    rd_chk(pao_pkg::OFF_ACC_UPPER, 8'h05);
    set3(pao_pkg::OFF_ACC_LOW, 20'h00000);
    set3(pao_pkg::OFF_STEP_LOW, 20'h12345);
    wr(pao_pkg::OFF_CONTROL, 8'h80);
    tick(3, 10'h001);
    rd_chk(pao_pkg::OFF_ACC_LOW, 8'hcf);
    rd_chk(pao_pkg::OFF_ACC_HIGH, 8'h69);
    rd_chk(pao_pkg::OFF_ACC_UPPER, 8'h03);
    wr(pao_pkg::OFF_CONTROL, 8'h00);
    tick(2, 10'h001);
    rd_chk(pao_pkg::OFF_ACC_LOW, 8'hcf);
    // fixed duty with the widest width code, which must have no effect
    set3(pao_pkg::OFF_ACC_LOW, 20'h00000);
    set3(pao_pkg::OFF_STEP_LOW, 20'h80000);
    wr(pao_pkg::OFF_CLOCK, 8'he0);
    b_rise = rise_cnt_ff;
    b_carry = carry_cnt_ff;
    wr(pao_pkg::OFF_CONTROL, 8'h80);
    tick(8, 10'h001);
    chk("carries", 16'h0004, carry_cnt_ff - b_carry);
    chk("fdc rises", 16'h0002, rise_cnt_ff - b_rise);
    for (int n = 0; n < 8; n++) begin
      wr(pao_pkg::OFF_CONTROL, 8'h00);
      set3(pao_pkg::OFF_ACC_LOW, 20'hfffff);
      set3(pao_pkg::OFF_STEP_LOW, 20'h00001);
      wr(pao_pkg::OFF_CLOCK, {3'(n), 5'h00});
      b_hi = hi_cnt_ff;
      wr(pao_pkg::OFF_CONTROL, 8'h81);
      tick((1 << n) + 3, 10'h001);
      chk("pulse cycles", 16'(2 << n), hi_cnt_ff - b_hi);
    end
    for (int c = 0; c < 16; c++) begin
      wr(pao_pkg::OFF_CONTROL, 8'h00);
      set3(pao_pkg::OFF_ACC_LOW, 20'h00000);
      wr(pao_pkg::OFF_CLOCK, {4'h0, 4'(c)});
      wr(pao_pkg::OFF_CONTROL, 8'h80);
      tick(4, (src_idx[c] === 4'hf) ? 10'h3ff : (10'h001 << src_idx[c]));
      rd_chk(pao_pkg::OFF_ACC_LOW, (src_idx[c] === 4'hf) ? 8'h00 : 8'h04);
    end
    // overflow every two edges against a 128-edge pulse
    wr(pao_pkg::OFF_CONTROL, 8'h00);
    set3(pao_pkg::OFF_STEP_LOW, 20'h80000);
    wr(pao_pkg::OFF_CLOCK, 8'he0);
    b_rise = rise_cnt_ff;
    wr(pao_pkg::OFF_CONTROL, 8'h81);
    tick(20, 10'h001);
    chk("long pulse rises", 16'h0001, rise_cnt_ff - b_rise);
    rd_chk(pao_pkg::OFF_CONTROL, 8'ha1);
    // reset again while the long pulse holds control, clock and step upper away from zero
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++) rd_chk(4'(i), 8'h00);
    close_out();
  end
endmodule : phase_accumulator_oscillator_tb
